// ---- iopr_pkg.sv ----
package iopr_pkg;

    // Clock and filter clock rates
    localparam int SYS_CLK_HZ = 100_000_000;
    localparam int FILT_FAST_HZ = 5_000_000;
    localparam int FILT_SLOW_HZ = 32_000;
    localparam int FILT_FAST_HALF = SYS_CLK_HZ / (2 * FILT_FAST_HZ);
    localparam int FILT_SLOW_HALF = SYS_CLK_HZ / (2 * FILT_SLOW_HZ);
    localparam int FILT_CNT_W = 11;

    // Configuration byte addresses and fields
    localparam logic [15:0] ADDR_COMP_STAT = 16'h2003;
    localparam logic [15:0] ADDR_CLK_OUT = 16'h2004;
    localparam int COMP_STAT_BIT = 0;
    localparam int CLK_OUT_EN_BIT = 4;
    localparam logic CLK_OUT_EN_RST = 1'b0;

    // Route fields: 0 pushbutton, then pins 1, 2, 4, 5, 6, 7, 8, 9
    localparam int NUM_ROUTE = 9;
    localparam int ROUTE_W = 3;
    localparam logic [15:0] ROUTE_ADDR [NUM_ROUTE] = '{
        16'h2009, 16'h2009, 16'h200A, 16'h200B, 16'h200B,
        16'h200C, 16'h200C, 16'h200D, 16'h200D};
    localparam int ROUTE_LSB [NUM_ROUTE] = '{0, 4, 0, 0, 4, 0, 4, 0, 4};
    localparam logic [2:0] ROUTE_RST = 3'h0;

    // Route codes
    localparam logic [2:0] RT_NONE = 3'h0;
    localparam logic [2:0] RT_RSVD = 3'h1;
    localparam logic [2:0] RT_TIMER0 = 3'h2;
    localparam logic [2:0] RT_TIMER1 = 3'h3;
    localparam logic [2:0] RT_HI_RISE = 3'h4;
    localparam logic [2:0] RT_LO_RISE = 3'h5;
    localparam logic [2:0] RT_HI_FALL = 3'h6;
    localparam logic [2:0] RT_LO_FALL = 3'h7;

    typedef logic [ROUTE_W-1:0] iopr_route_t;

    typedef struct packed {
        logic timer_zero_input;
        logic timer_one_input;
        logic high_priority_ext_interrupt;
        logic low_priority_ext_interrupt;
    } iopr_res_s;

endpackage : iopr_pkg

// ---- iopr_pin_route.sv ----
`timescale 1ns/100ps

module iopr_pin_route
    import iopr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [15:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    input wire logic cfg_we,
    input wire logic cfg_re,
    output logic [7:0] cfg_rdata,
    input wire logic [NUM_ROUTE-1:0] pin_in,
    input wire logic supply_ok_indication,
    input wire logic reduced_power_battery_mode,
    input wire logic lcd_segment_output,
    output logic seg_clk_pin,
    output iopr_res_s res_out
);

    // Input synchronisers
    logic [NUM_ROUTE-1:0] pin_meta_reg, pin_sync_reg;
    logic comp_meta_reg, comp_sync_reg;
    logic slow_meta_reg, slow_sync_reg;

    always_ff @(posedge clk_sys) begin
        pin_meta_reg <= pin_in;
        pin_sync_reg <= pin_meta_reg;
        comp_meta_reg <= supply_ok_indication;
        comp_sync_reg <= comp_meta_reg;
        slow_meta_reg <= reduced_power_battery_mode;
        slow_sync_reg <= slow_meta_reg;
    end

    // Configuration registers
    iopr_route_t route_reg [NUM_ROUTE];
    logic clk_out_en_reg;
    logic clk_out_hit;
    logic comp_hit;

    assign clk_out_hit = (cfg_addr == ADDR_CLK_OUT);
    assign comp_hit = (cfg_addr == ADDR_COMP_STAT);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            clk_out_en_reg <= CLK_OUT_EN_RST;
        end else if (cfg_we && clk_out_hit) begin
            clk_out_en_reg <= cfg_wdata[CLK_OUT_EN_BIT];
        end
    end

    // Per-pin route fields and resource selects
    logic [NUM_ROUTE-1:0] sel_t0, sel_t1, sel_hr, sel_lr, sel_hf, sel_lf;
    logic [NUM_ROUTE-1:0] route_hit;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_ROUTE; gi++) begin : g_route
            assign route_hit[gi] = cfg_we && (cfg_addr == ROUTE_ADDR[gi]);
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    route_reg[gi] <= ROUTE_RST;
                end else if (route_hit[gi]) begin
                    route_reg[gi] <= cfg_wdata[ROUTE_LSB[gi] +: ROUTE_W];
                end
            end
            // None and reserved codes match no select
            assign sel_t0[gi] = (route_reg[gi] == RT_TIMER0);
            assign sel_t1[gi] = (route_reg[gi] == RT_TIMER1);
            assign sel_hr[gi] = (route_reg[gi] == RT_HI_RISE);
            assign sel_lr[gi] = (route_reg[gi] == RT_LO_RISE);
            assign sel_hf[gi] = (route_reg[gi] == RT_HI_FALL);
            assign sel_lf[gi] = (route_reg[gi] == RT_LO_FALL);
        end
    endgenerate

    // OR of every pin picking a resource
    logic t0_lvl, t1_lvl, hr_lvl, lr_lvl, hf_lvl, lf_lvl;
    assign t0_lvl = |(pin_sync_reg & sel_t0);
    assign t1_lvl = |(pin_sync_reg & sel_t1);
    assign hr_lvl = |(pin_sync_reg & sel_hr);
    assign lr_lvl = |(pin_sync_reg & sel_lr);
    assign hf_lvl = |(pin_sync_reg & sel_hf);
    assign lf_lvl = |(pin_sync_reg & sel_lf);

    // Edge detection for interrupt inputs
    logic hr_prev_reg, lr_prev_reg, hf_prev_reg, lf_prev_reg;
    logic hi_evt, lo_evt;
    assign hi_evt = (hr_lvl && !hr_prev_reg) || (!hf_lvl && hf_prev_reg);
    assign lo_evt = (lr_lvl && !lr_prev_reg) || (!lf_lvl && lf_prev_reg);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hr_prev_reg <= 1'b0;
            lr_prev_reg <= 1'b0;
            hf_prev_reg <= 1'b0;
            lf_prev_reg <= 1'b0;
            res_out <= '0;
        end else begin
            hr_prev_reg <= hr_lvl;
            lr_prev_reg <= lr_lvl;
            hf_prev_reg <= hf_lvl;
            lf_prev_reg <= lf_lvl;
            res_out.timer_zero_input <= t0_lvl;
            res_out.timer_one_input <= t1_lvl;
            res_out.high_priority_ext_interrupt <= hi_evt;
            res_out.low_priority_ext_interrupt <= lo_evt;
        end
    end

    // Filter clock divider
    logic [FILT_CNT_W-1:0] filt_cnt_reg;
    logic [FILT_CNT_W-1:0] filt_half;
    logic filt_reg;
    logic slow_prev_reg;
    logic filt_wrap;
    assign filt_half = slow_sync_reg ? FILT_CNT_W'(FILT_SLOW_HALF)
                                     : FILT_CNT_W'(FILT_FAST_HALF);
    assign filt_wrap = (filt_cnt_reg == filt_half - 1'b1);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            filt_cnt_reg <= '0;
            filt_reg <= 1'b0;
            slow_prev_reg <= 1'b0;
        end else begin
            slow_prev_reg <= slow_sync_reg;
            if (slow_sync_reg != slow_prev_reg) begin
                filt_cnt_reg <= '0;
            end else if (filt_wrap) begin
                filt_cnt_reg <= '0;
                filt_reg <= !filt_reg;
            end else begin
                filt_cnt_reg <= filt_cnt_reg + 1'b1;
            end
        end
    end

    // Shared segment / clock pin
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            seg_clk_pin <= 1'b0;
        end else begin
            seg_clk_pin <= clk_out_en_reg ? filt_reg : lcd_segment_output;
        end
    end

    // Read path
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (comp_hit) begin
            rd_byte[COMP_STAT_BIT] = comp_sync_reg;
        end
        if (clk_out_hit) begin
            rd_byte[CLK_OUT_EN_BIT] = clk_out_en_reg;
        end
        for (int i = 0; i < NUM_ROUTE; i++) begin
            if (cfg_addr == ROUTE_ADDR[i]) begin
                rd_byte[ROUTE_LSB[i] +: ROUTE_W] = route_reg[i];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg_rdata <= 8'h00;
        end else if (cfg_re) begin
            cfg_rdata <= rd_byte;
        end
    end

    // Checks
    // Fast-mode rise with no mode change under way
    sequence s_fast_high;
        $rose(filt_reg) && !slow_sync_reg && !slow_prev_reg;
    endsequence

    sequence s_comp_read;
        cfg_re && comp_hit;
    endsequence

    a_route_reset_none: assert property (@(posedge clk_sys)
        rst |=> (route_reg[0] == RT_NONE) && (route_reg[8] == RT_NONE))
        else $error("route field not cleared by reset");

    a_seg_follows_lcd: assert property (@(posedge clk_sys)
        disable iff (rst)
        !clk_out_en_reg |=> seg_clk_pin == $past(lcd_segment_output))
        else $error("segment pin not following lcd");

    a_filt_fast_half: assert property (@(posedge clk_sys)
        disable iff (rst || slow_sync_reg)
        s_fast_high |-> ##(FILT_FAST_HALF - 1) filt_reg ##1 !filt_reg)
        else $error("filter clock half period wrong");

    a_comp_status_read: assert property (@(posedge clk_sys)
        disable iff (rst)
        s_comp_read |=> cfg_rdata == {7'h00, $past(comp_sync_reg)})
        else $error("comparator status wrong");

    a_timer0_or_pins: assert property (@(posedge clk_sys)
        disable iff (rst)
        |(pin_sync_reg & sel_t0) |=> res_out.timer_zero_input)
        else $error("timer 0 input missed");

    a_timer1_or_pins: assert property (@(posedge clk_sys)
        disable iff (rst)
        !(|(pin_sync_reg & sel_t1)) |=> !res_out.timer_one_input)
        else $error("timer 1 input spurious");

    a_hi_rise_int: assert property (@(posedge clk_sys)
        disable iff (rst)
        $rose(hr_lvl) |-> ##1 res_out.high_priority_ext_interrupt)
        else $error("high rise interrupt missed");

    a_lo_fall_int: assert property (@(posedge clk_sys)
        disable iff (rst)
        $fell(lf_lvl) |-> ##1 res_out.low_priority_ext_interrupt)
        else $error("low fall interrupt missed");

    a_hi_fall_int: assert property (@(posedge clk_sys)
        disable iff (rst)
        $fell(hf_lvl) |-> ##1 res_out.high_priority_ext_interrupt)
        else $error("high fall interrupt missed");

    a_lo_rise_int: assert property (@(posedge clk_sys)
        disable iff (rst)
        $rose(lr_lvl) |-> ##1 res_out.low_priority_ext_interrupt)
        else $error("low rise interrupt missed");

    a_int_needs_edge: assert property (@(posedge clk_sys)
        disable iff (rst)
        (!hr_lvl && !hf_prev_reg) |=> !res_out.high_priority_ext_interrupt)
        else $error("high interrupt without edge");

endmodule : iopr_pin_route

// ---- iopr_far_end.sv ----
`timescale 1ns/100ps
module iopr_far_end
    import iopr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [NUM_ROUTE-1:0] pin_req,
    input wire logic ok_req,
    input wire logic batt_req,
    input wire logic seg_req,
    output logic [NUM_ROUTE-1:0] pin_in = '0,
    output logic supply_ok_indication = 1'b0,
    output logic reduced_power_battery_mode = 1'b0,
    output logic lcd_segment_output = 1'b0
);
    // Pins and comparator change away from the sampling edge
    always @(negedge clk_sys) begin
        pin_in <= pin_req;
        supply_ok_indication <= ok_req;
        reduced_power_battery_mode <= batt_req;
        lcd_segment_output <= seg_req;
    end
endmodule : iopr_far_end

// ---- tb.sv ----
`timescale 1ns/100ps
module tb;
    import iopr_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [15:0] cfg_addr = 16'h0000;
    logic [7:0] cfg_wdata = 8'h00;
    logic cfg_we = 1'b0;
    logic cfg_re = 1'b0;
    logic [7:0] cfg_rdata;
    logic [NUM_ROUTE-1:0] pin_in;
    logic [NUM_ROUTE-1:0] pin_req = '0;
    logic ok_in, batt_in, seg_in, seg_clk_pin;
    logic ok_req = 1'b0, batt_req = 1'b0, seg_req = 1'b0, seg_prev = 1'b0;
    iopr_res_s res_out;
    int n_mismatch = 0, n_checks = 0, n_cyc = 0, n_hi = 0, n_lo = 0;
    int per_cnt = 0, per_last = 0;
    always #5 clk_sys = ~clk_sys;
    iopr_pin_route DUT (.clk_sys(clk_sys), .rst(rst), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_we(cfg_we), .cfg_re(cfg_re),
        .cfg_rdata(cfg_rdata), .pin_in(pin_in),
        .supply_ok_indication(ok_in), .reduced_power_battery_mode(batt_in),
        .lcd_segment_output(seg_in), .seg_clk_pin(seg_clk_pin),
        .res_out(res_out));
    iopr_far_end far_end (.clk_sys(clk_sys), .pin_req(pin_req),
        .ok_req(ok_req), .batt_req(batt_req), .seg_req(seg_req),
        .pin_in(pin_in), .supply_ok_indication(ok_in),
        .reduced_power_battery_mode(batt_in), .lcd_segment_output(seg_in));
    // Pulse counts, pin period and timeout
    always @(negedge clk_sys) begin
        n_cyc++;
        if (res_out.high_priority_ext_interrupt === 1'b1) n_hi++;
        if (res_out.low_priority_ext_interrupt === 1'b1) n_lo++;
        if (seg_clk_pin === 1'b1 && seg_prev === 1'b0) begin
            per_last = per_cnt;
            per_cnt = 1;
        end else per_cnt++;
        seg_prev = seg_clk_pin;
        if (n_cyc == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        cfg_addr = a;
        cfg_wdata = d;
        cfg_we = 1'b1;
        @(negedge clk_sys);
        cfg_we = 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        cfg_addr = a;
        cfg_re = 1'b1;
        @(negedge clk_sys);
        cfg_re = 1'b0;
        chk("cfg_rdata", {24'h0, e}, {24'h0, cfg_rdata});
    endtask : rd
    task automatic pins(input logic [NUM_ROUTE-1:0] v);
        @(posedge clk_sys);
        pin_req = v;
        repeat (6) @(negedge clk_sys);
    endtask : pins
    initial begin
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        for (int i = 9; i <= 13; i++) rd(16'h2000 + i[15:0], 8'h00);
        rd(16'h2004, 8'h00);
        rd(16'h2010, 8'h00);
        $display("test reset done");
        ok_req = 1'b1;
        repeat (4) @(negedge clk_sys);
        rd(16'h2003, 8'h01);
        ok_req = 1'b0;
        repeat (4) @(negedge clk_sys);
        rd(16'h2003, 8'h00);
        $display("test status done");
        wr(16'h2009, 8'h22);
        rd(16'h2009, 8'h22);
        pins(9'h002);
        chk("timer0", 1, res_out.timer_zero_input);
        pins(9'h001);
        chk("timer0", 1, res_out.timer_zero_input);
        pins(9'h000);
        chk("timer0", 0, res_out.timer_zero_input);
        wr(16'h200A, 8'h03);
        pins(9'h004);
        chk("timer1", 1, res_out.timer_one_input);
        chk("timer0", 0, res_out.timer_zero_input);
        pins(9'h000);
        $display("test timers done");
        for (int c = 0; c < 8; c++) begin
            wr(16'h200B, c[7:0]);
            n_hi = 0;
            n_lo = 0;
            pins(9'h008);
            chk("hi_rise", c == 4, n_hi);
            chk("lo_rise", c == 5, n_lo);
            pins(9'h000);
            chk("hi_all", c == 4 || c == 6, n_hi);
            chk("lo_all", c == 5 || c == 7, n_lo);
        end
        $display("test interrupts done");
        seg_req = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk("seg_pin", 1, seg_clk_pin);
        seg_req = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk("seg_pin", 0, seg_clk_pin);
        wr(16'h2004, 8'h10);
        rd(16'h2004, 8'h10);
        repeat (80) @(negedge clk_sys);
        chk("fast_period", 2 * FILT_FAST_HALF, per_last);
        batt_req = 1'b1;
        repeat (6 * FILT_SLOW_HALF) @(negedge clk_sys);
        chk("slow_period", 2 * FILT_SLOW_HALF, per_last);
        $display("test clock pin done");
        stop_test();
    end
endmodule : tb
